//--- design/contact_qualifier.sv
// One remote input: two-stage synchroniser and hold-time qualifier
`timescale 1ns/1ps
module contact_qualifier
    import remote_contact_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic rawIn,
    output logic      pulse,
    output logic      level
);

    localparam int unsigned CW = $clog2(QUAL_CYCLES + 1);

    logic          syncA_ff;
    logic          syncB_ff;
    logic [CW-1:0] count_ff;
    logic          held_ff;
    logic          pulse_ff;
    logic          full;
    logic [CW-1:0] nxt_count;

    assign full = (count_ff == CW'(QUAL_CYCLES - 1));
    // Any drop restarts the hold timer
    assign nxt_count = !syncB_ff ? '0 :
                       (held_ff ? count_ff : count_ff + 1'b1);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            count_ff <= '0;
            held_ff  <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            syncA_ff <= rawIn;
            syncB_ff <= syncA_ff;
            count_ff <= nxt_count;
            held_ff  <= syncB_ff && (held_ff || full);
            // One event per activation, even if held on
            pulse_ff <= syncB_ff && full && !held_ff;
        end
    end

    assign pulse = pulse_ff;
    assign level = held_ff;

endmodule

//--- design/remote_contact_control.sv
// Remote contact inputs, tallies, watchdog and reload mute with APB registers
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module remote_contact_control
    import remote_contact_pkg::*;
#(
    parameter int unsigned WDOG_LIMIT = WDOG_CYCLES,
    parameter int unsigned MUTE_LIMIT = MUTE_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          resetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [7:0]    remoteContactInput,
    input  wire logic          panelValid,
    input  wire command_t      panelCmd,
    input  wire logic          serialValid,
    input  wire command_t      serialCmd,
    input  wire logic          reloadDone,
    input  wire audio_status_t audioStatus,
    output command_t           activeCmd,
    output logic               cmdStrobe,
    output logic               analogSelect,
    output logic [1:0]         tallyOut,
    output logic               tallyOe,
    output logic               cpuResetn,
    output logic               reloadReq,
    output logic               audioMute,
    output logic               irq
);

    ////////////////////////////////////////////////////////////////////////
    // Input qualification

    logic [7:0] qualPulse;
    logic [7:0] qualLevel;

    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
        contact_qualifier u_qual (
            .mclk   (mclk),
            .resetn (resetn),
            .rawIn  (remoteContactInput[i]),
            .pulse  (qualPulse[i]),
            .level  (qualLevel[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0]        actMap_ff;
    logic [31:0]        preset_ff;
    logic [5:0]         tallyCfg_ff;
    logic [IRQ_W-1:0]   irqStat_ff;
    logic [IRQ_W-1:0]   irqEn_ff;
    logic [31:0]        prdata_ff;
    logic               pready_ff;
    logic               pslverr_ff;

    logic               access;
    logic               wrEn;
    logic               rdEn;
    logic               mapped;
    logic               wrActMap;
    logic               wrPreset;
    logic               wrTally;
    logic               wrCmd;
    logic               wrClr;
    logic               wrEn_irq;
    logic               wrWdog;
    logic [31:0]        rdMux;

    // One-wait slave: answer in the access cycle's following edge
    assign access   = psel && penable && !pready_ff;
    assign wrEn     = access && pwrite;
    assign rdEn     = access && !pwrite;
    assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= OFF_INPUTS);
    assign wrActMap = wrEn && paddr == OFF_ACTMAP;
    assign wrPreset = wrEn && paddr == OFF_PRESET;
    assign wrTally  = wrEn && paddr == OFF_TALLYCFG;
    assign wrCmd    = wrEn && paddr == OFF_COMMAND;
    assign wrClr    = wrEn && paddr == OFF_IRQCLR;
    assign wrEn_irq = wrEn && paddr == OFF_IRQEN;
    assign wrWdog   = wrEn && paddr == OFF_WDOG
                      && pwdata[15:0] == WDOG_KEY;

    ////////////////////////////////////////////////////////////////////////
    // Command arbitration

    function automatic action_t mapAction(input logic [31:0] map,
                                          input logic [2:0]  idx);
        return action_t'(map[{idx, 2'b00} +: 3]);
    endfunction

    function automatic logic [2:0] lowestSet(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int k = NUM_INPUTS - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    logic       remoteHit;
    logic [2:0] remoteIdx;
    command_t   remoteCmd;
    logic       swCmdHit;
    command_t   swCmd;
    command_t   nxt_cmd;
    logic       anyCmd;
    command_t   cmd_ff;
    logic       strobe_ff;
    logic       analog_ff;

    assign remoteHit = |qualPulse;
    assign remoteIdx = lowestSet(qualPulse);
    assign remoteCmd = '{src:   SRC_REMOTE,
                         act:   mapAction(actMap_ff, remoteIdx),
                         param: preset_ff[{remoteIdx, 2'b00} +: 4]};
    assign swCmdHit  = wrCmd;
    assign swCmd     = command_t'(pwdata[8:0]);

    // Same-cycle ties resolve to one fixed order; otherwise later wins
    assign anyCmd  = remoteHit || serialValid || panelValid || swCmdHit;
    assign nxt_cmd = remoteHit   ? remoteCmd :
                     serialValid ? serialCmd :
                     panelValid  ? panelCmd  :
                     swCmdHit    ? swCmd     : cmd_ff;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmd_ff    <= '{src: SRC_PANEL, act: ACT_ANALOG_IN, param: 4'h0};
            strobe_ff <= 1'b0;
            analog_ff <= 1'b1;
        end else begin
            cmd_ff    <= nxt_cmd;
            strobe_ff <= anyCmd;
            if (anyCmd && nxt_cmd.act == ACT_ANALOG_IN) begin
                analog_ff <= 1'b1;
            end else if (anyCmd && nxt_cmd.act == ACT_DIGITAL_IN) begin
                analog_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tallies

    function automatic logic tallyPick(input logic [2:0]    sel,
                                       input logic          ana,
                                       input audio_status_t st);
        case (tally_t'(sel))
            TALLY_ANALOG_SEL:     return ana;
            TALLY_DIGITAL_SEL:    return !ana;
            TALLY_ANALOG_SILENT:  return st.analogSilent;
            TALLY_DIGITAL_SILENT: return st.digitalSilent;
            TALLY_DIGITAL_ERROR:  return st.digitalError;
            default:              return 1'b0;
        endcase
    endfunction

    logic [1:0] tally_ff;
    logic [1:0] nxt_tally;

    assign nxt_tally[0] = tallyPick(tallyCfg_ff[2:0], analog_ff,
                                    audioStatus);
    assign nxt_tally[1] = tallyPick(tallyCfg_ff[5:3], analog_ff,
                                    audioStatus);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tally_ff <= 2'b00;
        end else begin
            tally_ff <= nxt_tally;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, reboot and reload mute

    typedef enum logic [1:0] {
        ST_RUN,
        ST_REBOOT,
        ST_RELOAD
    } sys_state_t;

    sys_state_t  state_ff;
    sys_state_t  nxt_state;
    logic [31:0] wdog_ff;
    logic [31:0] timer_ff;
    logic [31:0] nxt_timer;
    logic        wdogExpire;
    logic        muteEnd;

    assign wdogExpire = (state_ff == ST_RUN) &&
                        (wdog_ff == WDOG_LIMIT - 1);
    // Mute ends on done, or after the nominal second as a backstop
    assign muteEnd    = (state_ff == ST_RELOAD) &&
                        (reloadDone || timer_ff == MUTE_LIMIT - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff + 32'h1;
        case (state_ff)
            ST_RUN: begin
                if (wdogExpire) begin
                    nxt_state = ST_REBOOT;
                    nxt_timer = 32'h0;
                end
            end
            // Audio still runs here; mute waits for the reload itself
            ST_REBOOT: begin
                if (timer_ff == RESET_PULSE - 1) begin
                    nxt_state = ST_RELOAD;
                    nxt_timer = 32'h0;
                end
            end
            ST_RELOAD: begin
                if (muteEnd) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff <= ST_RUN;
            timer_ff <= 32'h0;
            wdog_ff  <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            wdog_ff  <= (wrWdog || state_ff != ST_RUN) ? 32'h0
                        : wdog_ff + 32'h1;
        end
    end

    logic cpuResetn_ff;
    logic reload_ff;
    logic mute_ff;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cpuResetn_ff <= 1'b1;
            reload_ff    <= 1'b0;
            mute_ff      <= 1'b0;
        end else begin
            cpuResetn_ff <= nxt_state != ST_REBOOT;
            reload_ff    <= nxt_state == ST_RELOAD;
            mute_ff      <= nxt_state == ST_RELOAD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and interrupts

    logic [IRQ_W-1:0] events;

    assign events = {muteEnd, wdogExpire, remoteHit};

    assign rdMux =
        paddr == OFF_ACTMAP   ? actMap_ff :
        paddr == OFF_PRESET   ? preset_ff :
        paddr == OFF_TALLYCFG ? {26'h0, tallyCfg_ff} :
        paddr == OFF_COMMAND  ? {23'h0, cmd_ff} :
        paddr == OFF_STATE    ? {26'h0, tally_ff, mute_ff, analog_ff,
                                 2'(state_ff)} :
        paddr == OFF_IRQSTAT  ? {29'h0, irqStat_ff} :
        paddr == OFF_IRQEN    ? {29'h0, irqEn_ff} :
        paddr == OFF_INPUTS   ? {24'h0, qualLevel} : 32'h0;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            actMap_ff   <= ACTMAP_RST;
            preset_ff   <= PRESET_RST;
            tallyCfg_ff <= TALLYCFG_RST;
            irqEn_ff    <= '0;
            irqStat_ff  <= '0;
            prdata_ff   <= 32'h0;
            pready_ff   <= 1'b0;
            pslverr_ff  <= 1'b0;
        end else begin
            if (wrActMap) begin
                actMap_ff <= pwdata;
            end
            if (wrPreset) begin
                preset_ff <= pwdata;
            end
            if (wrTally) begin
                tallyCfg_ff <= pwdata[5:0];
            end
            if (wrEn_irq) begin
                irqEn_ff <= pwdata[IRQ_W-1:0];
            end
            // Set wins over a clear in the same cycle
            irqStat_ff <= (irqStat_ff & ~(wrClr ? pwdata[IRQ_W-1:0] : '0))
                          | events;
            pready_ff  <= access;
            pslverr_ff <= access && !mapped;
            prdata_ff  <= rdEn ? rdMux : 32'h0;
        end
    end

    logic irq_ff;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irqStat_ff & irqEn_ff);
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign activeCmd    = cmd_ff;
    assign cmdStrobe    = strobe_ff;
    assign analogSelect = analog_ff;
    assign tallyOut     = tally_ff;
    assign tallyOe      = 1'b1;
    assign cpuResetn    = cpuResetn_ff;
    assign reloadReq    = reload_ff;
    assign audioMute    = mute_ff;
    assign irq          = irq_ff;

endmodule

//--- dv/contact_bank.sv
// Partner model: bank of eight remote contacts with bounce
`timescale 1ns/1ps
module contact_bank
    import remote_contact_pkg::*;
#(
    parameter int unsigned BOUNCE = 5
) (
    input  wire logic       mclk,
    input  wire logic [7:0] pressReq,
    output logic      [7:0] contacts
);
    logic [7:0] lastReq_ff = 8'h00;
    logic [7:0] chatter_ff = 8'h00;
    int         bounce_ff  = 0;
    initial contacts = 8'h00;
    // Real contacts chatter on every change, so never settle at once
    always @(posedge mclk) begin
        lastReq_ff <= pressReq;
        if (pressReq != lastReq_ff) begin
            bounce_ff  <= BOUNCE;
            chatter_ff <= pressReq ^ lastReq_ff;
        end else if (bounce_ff > 0) begin
            bounce_ff <= bounce_ff - 1;
        end
        contacts <= (bounce_ff > 0) ? contacts ^ chatter_ff : pressReq;
    end
endmodule

//--- dv/remote_contact_control_sva.sv
// Checker: port-level assertions of the remote contact block
`timescale 1ns/1ps
module remote_contact_control_sva
    import remote_contact_pkg::*;
#(
    parameter int unsigned WDOG_LIMIT = 200,
    parameter int unsigned MUTE_LIMIT = 100
) (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [7:0]  remoteContactInput,
    input wire logic        panelValid,
    input wire command_t    panelCmd,
    input wire logic        serialValid,
    input wire command_t    serialCmd,
    input wire command_t    activeCmd,
    input wire logic        cmdStrobe,
    input wire logic        cpuResetn,
    input wire logic        reloadReq,
    input wire logic        audioMute
);
    command_t    expCmd_ff;
    logic [4:0]  lowCnt_ff;
    logic [31:0] muteCnt_ff;
    logic [31:0] holdCnt_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            expCmd_ff  <= '0;
            lowCnt_ff  <= 5'h00;
            muteCnt_ff <= 32'h0;
            holdCnt_ff <= 32'h0;
        end else begin
            if (serialValid) expCmd_ff <= serialCmd;
            else if (panelValid) expCmd_ff <= panelCmd;
            lowCnt_ff  <= cpuResetn ? 5'h00 : lowCnt_ff + 5'h01;
            muteCnt_ff <= audioMute ? muteCnt_ff + 32'h1 : 32'h0;
            holdCnt_ff <= |remoteContactInput ? holdCnt_ff + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    ready_follows_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered in one cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data shown outside an answer");
    latest_wins_a: assert property ((serialValid || panelValid) ##1
        (!serialValid && !panelValid)[*3] |-> activeCmd == expCmd_ff)
        else $error("latest command not applied");
    reboot_len_a: assert property ($rose(cpuResetn) |-> lowCnt_ff == 5'h10)
        else $error("reboot pulse not 16 cycles");
    reboot_max_a: assert property (lowCnt_ff <= 5'h10)
        else $error("reboot pulse too long");
    audio_live_a: assert property (!cpuResetn |-> !audioMute)
        else $error("audio muted before reload");
    mute_start_a: assert property ($rose(cpuResetn) |-> ##[0:1] audioMute)
        else $error("no mute during reload");
    mute_pair_a: assert property (audioMute == reloadReq)
        else $error("mute and reload request differ");
    mute_bound_a: assert property (muteCnt_ff <= MUTE_LIMIT + 2)
        else $error("mute outlasts its limit");
    remote_hold_a: assert property (cmdStrobe && activeCmd.src == SRC_REMOTE
        |-> holdCnt_ff >= QUAL_CYCLES)
        else $error("remote command without full hold");
endmodule
bind remote_contact_control remote_contact_control_sva #(
    .WDOG_LIMIT(WDOG_LIMIT), .MUTE_LIMIT(MUTE_LIMIT)
) u_sva (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .remoteContactInput(remoteContactInput),
    .panelValid(panelValid), .panelCmd(panelCmd), .serialValid(serialValid),
    .serialCmd(serialCmd), .activeCmd(activeCmd), .cmdStrobe(cmdStrobe),
    .cpuResetn(cpuResetn), .reloadReq(reloadReq), .audioMute(audioMute)
);

//--- dv/remote_contact_control_tb.sv
// Testbench: self-checking bench of the remote contact block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    tests_run++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("unexpected %s: expected %h seen %h", nm, exp, got); \
    end
module remote_contact_control_tb;
    import remote_contact_pkg::*;
    localparam int unsigned WDOG_T = 3000;
    localparam int unsigned MUTE_T = 100;
    logic          mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]    paddr, pressReq, contacts;
    logic [31:0]   pwdata, prdata, rd;
    logic          panelValid, serialValid, reloadDone, cmdStrobe, er;
    command_t      panelCmd, serialCmd, activeCmd, c;
    audio_status_t audioStatus;
    logic [1:0]    tallyOut;
    logic          analogSelect, tallyOe, cpuResetn, reloadReq, audioMute;
    logic          irq, anaModel;
    int            err_total, tests_run, cyc, n, t0;
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) cyc++;
    contact_bank u_contacts (.mclk(mclk), .pressReq(pressReq),
        .contacts(contacts));
    remote_contact_control #(.WDOG_LIMIT(WDOG_T), .MUTE_LIMIT(MUTE_T)) u_dut (
        .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .remoteContactInput(contacts),
        .panelValid(panelValid), .panelCmd(panelCmd),
        .serialValid(serialValid), .serialCmd(serialCmd),
        .reloadDone(reloadDone), .audioStatus(audioStatus),
        .activeCmd(activeCmd), .cmdStrobe(cmdStrobe),
        .analogSelect(analogSelect), .tallyOut(tallyOut), .tallyOe(tallyOe),
        .cpuResetn(cpuResetn), .reloadReq(reloadReq), .audioMute(audioMute),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && k++ < 20);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] v, input logic e);
        apb(1'b0, a, 32'h0);
        `CHK("read data", v, rd)
        `CHK("pslverr", e, er)
    endtask
    task automatic cmd(input logic ser, input command_t v);
        int k;
        k = 0;
        @(posedge mclk);
        serialValid <= ser;
        panelValid  <= !ser;
        serialCmd   <= v;
        panelCmd    <= v;
        @(posedge mclk);
        serialValid <= 1'b0;
        panelValid  <= 1'b0;
        do @(negedge mclk); while (cmdStrobe !== 1'b1 && k++ < 4);
        `CHK("cmdStrobe", 1'b1, cmdStrobe)
        if (v.act == ACT_ANALOG_IN) anaModel = 1'b1;
        if (v.act == ACT_DIGITAL_IN) anaModel = 1'b0;
        @(negedge mclk);
        `CHK("activeCmd", v, activeCmd)
        `CHK("analogSelect", anaModel, analogSelect)
    endtask
    function automatic logic tallyExp(input logic [2:0] k, input logic ana,
                                      input audio_status_t s);
        case (k)
            3'h0: return ana;
            3'h1: return !ana;
            3'h2: return s.analogSilent;
            3'h3: return s.digitalSilent;
            3'h4: return s.digitalError;
            default: return 1'b0;
        endcase
    endfunction
    task automatic waitFor(input logic want, input int lim);
        t0 = cyc;
        while (cpuResetn !== want && cyc - t0 < lim) @(negedge mclk);
    endtask
    task results;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, pressReq} = '0;
        {panelValid, serialValid, panelCmd, serialCmd, audioStatus} = '0;
        reloadDone = 1'b0;
        anaModel = 1'b1;
        void'($urandom(32'h010b));
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values, reserved and unmapped places
        `CHK("analogSelect", 1'b1, analogSelect)
        rdchk(OFF_ACTMAP, ACTMAP_RST, 1'b0);
        rdchk(OFF_TALLYCFG, {26'h0, TALLYCFG_RST}, 1'b0);
        rdchk(OFF_RELOAD, 32'h0, 1'b0);
        rdchk(8'h02, 32'h0, 1'b1);
        n = $urandom & 32'h77777777;
        apb(1'b1, OFF_ACTMAP, n);
        apb(1'b1, 8'h2c, ~n);
        rdchk(OFF_ACTMAP, n, 1'b0);
        rdchk(8'h2c, 32'h0, 1'b1);
        $display("test registers done");
        // Every action, then latest-wins ordering
        for (int a = 0; a < 8; a++) begin
            c = '{a[0] ? SRC_SERIAL : SRC_PANEL, action_t'(a), 4'($urandom)};
            cmd(a[0], c);
        end
        @(posedge mclk);
        panelValid <= 1'b1;
        panelCmd   <= '{SRC_PANEL, ACT_ANALOG_IN, 4'h3};
        anaModel = 1'b1;
        @(posedge mclk);
        panelValid  <= 1'b0;
        serialValid <= 1'b1;
        serialCmd   <= '{SRC_SERIAL, ACT_MONO, 4'h9};
        @(posedge mclk);
        panelValid  <= 1'b1;
        serialCmd   <= '{SRC_SERIAL, ACT_STEREO, 4'h1};
        @(posedge mclk);
        panelValid  <= 1'b0;
        serialValid <= 1'b0;
        repeat (4) @(negedge mclk);
        `CHK("activeCmd", serialCmd, activeCmd)
        `CHK("analogSelect", anaModel, analogSelect)
        c = '{SRC_SERIAL, ACT_ANALOG_IN, 4'h5};
        apb(1'b1, OFF_COMMAND, {23'h0, c});
        anaModel = 1'b1;
        rdchk(OFF_COMMAND, {23'h0, c}, 1'b0);
        `CHK("analogSelect", anaModel, analogSelect)
        $display("test commands done");
        // Each tally code on both outputs
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, OFF_TALLYCFG, {26'h0, 3'(7 - k), 3'(k)});
            audioStatus <= 3'($urandom);
            repeat (4) @(negedge mclk);
            `CHK("tally0", tallyExp(3'(k), anaModel, audioStatus), tallyOut[0])
            `CHK("tally1", tallyExp(3'(7 - k), anaModel, audioStatus), tallyOut[1])
        end
        $display("test tallies done");
        // Holds shorter than the qualifying time; a full hold is too long
        apb(1'b1, OFF_WDOG, {16'h0, WDOG_KEY});
        @(posedge mclk);
        pressReq <= 8'($urandom) | 8'h01;
        n = 0;
        repeat (1500) @(negedge mclk) n += int'(cmdStrobe === 1'b1);
        @(posedge mclk);
        pressReq <= 8'h00;
        repeat (20) @(negedge mclk) n += int'(cmdStrobe === 1'b1);
        `CHK("early strobes", 0, n)
        rdchk(OFF_INPUTS, 32'h0, 1'b0);
        $display("test remote inputs done");
        // Watchdog expiry, reboot, reload mute and interrupts
        apb(1'b1, OFF_IRQCLR, 32'h7);
        apb(1'b1, OFF_IRQEN, 32'h6);
        apb(1'b1, OFF_WDOG, {16'h0, WDOG_KEY});
        n = cyc;
        apb(1'b1, OFF_WDOG, 32'h1234);
        waitFor(1'b0, 2 * WDOG_T);
        `CHK("expiry", 1'b1, cyc - n >= WDOG_T - 3 && cyc - n <= WDOG_T + 3)
        waitFor(1'b1, 40);
        `CHK("reboot length", 16, cyc - t0)
        n = cyc;
        while (audioMute === 1'b1 && cyc - n < 300) @(negedge mclk);
        `CHK("mute length", 1'b1, cyc - n >= MUTE_T - 2 && cyc - n <= MUTE_T + 2)
        repeat (2) @(negedge mclk);
        `CHK("irq", 1'b1, irq)
        rdchk(OFF_IRQSTAT, 32'h6, 1'b0);
        apb(1'b1, OFF_IRQEN, 32'h0);
        repeat (2) @(negedge mclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, OFF_IRQEN, 32'h6);
        apb(1'b1, OFF_IRQCLR, 32'h6);
        rdchk(OFF_IRQSTAT, 32'h0, 1'b0);
        `CHK("irq cleared", 1'b0, irq)
        waitFor(1'b0, 2 * WDOG_T);
        waitFor(1'b1, 40);
        repeat (10) @(posedge mclk);
        `CHK("mute held", 1'b1, audioMute)
        reloadDone <= 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("mute released", 1'b0, audioMute)
        reloadDone <= 1'b0;
        $display("test watchdog done");
        results();
    end
endmodule

//--- include/remote_contact_pkg.sv
// Package: constants, types and register map of the remote contact block
package remote_contact_pkg;

    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned QUAL_MS       = 50;
    // Least time rounds down to whole cycles, at least one
    localparam int unsigned QUAL_CYCLES   =
        (CLK_HZ / 1000 * QUAL_MS + 0) == 0 ? 1 : CLK_HZ / 1000 * QUAL_MS;
    localparam int unsigned MUTE_MS       = 1000;
    localparam int unsigned MUTE_CYCLES   = CLK_HZ / 1000 * MUTE_MS;
    localparam int unsigned WDOG_MS       = 1000;
    localparam int unsigned WDOG_CYCLES   = CLK_HZ / 1000 * WDOG_MS;
    localparam int unsigned RESET_PULSE   = 16;

    localparam int unsigned NUM_INPUTS    = 8;
    localparam int unsigned NUM_TALLY     = 2;

    // Register byte offsets
    localparam logic [7:0] OFF_ACTMAP     = 8'h00;
    localparam logic [7:0] OFF_PRESET     = 8'h04;
    localparam logic [7:0] OFF_TALLYCFG   = 8'h08;
    localparam logic [7:0] OFF_COMMAND    = 8'h0c;
    localparam logic [7:0] OFF_STATE      = 8'h10;
    localparam logic [7:0] OFF_IRQSTAT    = 8'h14;
    localparam logic [7:0] OFF_IRQCLR     = 8'h18;
    localparam logic [7:0] OFF_IRQEN      = 8'h1c;
    localparam logic [7:0] OFF_WDOG       = 8'h20;
    localparam logic [7:0] OFF_RELOAD     = 8'h24;
    localparam logic [7:0] OFF_INPUTS     = 8'h28;

    localparam logic [31:0] ACTMAP_RST    = 32'h00000000;
    localparam logic [31:0] PRESET_RST    = 32'h00000000;
    localparam logic [5:0]  TALLYCFG_RST  = 6'h00;
    localparam logic [15:0] WDOG_KEY      = 16'h5a5a;

    // Field widths and positions
    localparam int unsigned TALLY_FIELD_W = 3;
    localparam int unsigned CMD_SRC_POS   = 8;
    localparam int unsigned ACT_PARAM_POS = 4;

    // Interrupt status bits
    localparam int unsigned IRQ_REMOTE    = 0;
    localparam int unsigned IRQ_WDOG      = 1;
    localparam int unsigned IRQ_MUTEDONE  = 2;
    localparam int unsigned IRQ_W         = 3;

    typedef enum logic [2:0] {
        ACT_USER_PRESET,
        ACT_FACTORY_PRESET,
        ACT_BYPASS,
        ACT_TEST_TONE,
        ACT_STEREO,
        ACT_MONO,
        ACT_ANALOG_IN,
        ACT_DIGITAL_IN
    } action_t;

    typedef enum logic [1:0] {
        SRC_PANEL,
        SRC_REMOTE,
        SRC_SERIAL
    } source_t;

    typedef enum logic [2:0] {
        TALLY_ANALOG_SEL,
        TALLY_DIGITAL_SEL,
        TALLY_ANALOG_SILENT,
        TALLY_DIGITAL_SILENT,
        TALLY_DIGITAL_ERROR
    } tally_t;

    // Most recent control operation, whatever its source
    typedef struct packed {
        source_t    src;
        action_t    act;
        logic [3:0] param;
    } command_t;

    // Audio conditions that feed the tallies
    typedef struct packed {
        logic analogSilent;
        logic digitalSilent;
        logic digitalError;
    } audio_status_t;

endpackage
